//--- design/plsc_regs.vh
// Register offsets, field positions and reset values for the lane status / link config slice
`ifndef PLSC_REGS_VH
`define PLSC_REGS_VH
`define PLSC_ADDR_W 12
`define PLSC_OFS_LANE_STS 12'h520
`define PLSC_OFS_LINK_CFG 12'h530
`define PLSC_OFS_IRQ_STS 12'h534
`define PLSC_OFS_IRQ_MASK 12'h538
`define PLSC_UND_LSB 0
`define PLSC_OVR_LSB 16
`define PLSC_COMPAT_BIT 8
`define PLSC_XLINK_BIT 11
`define PLSC_SPEED_BIT 14
`define PLSC_LANE_STS_RST 32'h00000000
`define PLSC_SPEED_RST_DSP 1'b0
`define PLSC_SPEED_RST_OTHER 1'b1
`define PLSC_IRQ_UND_BIT 0
`define PLSC_IRQ_OVR_BIT 1
`endif

//--- design/plsc_lane_flag.v
// One sticky write-one-to-clear lane flag with L0 qualification
`timescale 1ns/1ns
`default_nettype none
module plsc_lane_flag (
  input wire sys_clk,
  input wire rst_n,
  input wire event_in,
  input wire in_l0,
  input wire lane_valid,
  input wire clr_in,
  output wire flag
);
  reg flag_r;
  reg flag_nxt;

  // Set wins over a clear in the same cycle; events outside L0 are dropped
  always @* begin
    flag_nxt = flag_r;
    if (clr_in) begin
      flag_nxt = 1'b0;
    end
    if (event_in && in_l0 && lane_valid) begin
      flag_nxt = 1'b1;
    end
  end

  // Only fundamental reset and a write-one-to-clear clear the flag
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;
endmodule
`default_nettype wire

//--- design/plsc_top.v
// Per-port physical layer lane status and link configuration register slice
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "plsc_regs.vh"
module plsc_top #(
  parameter LANES = 8,
  parameter ODD_PORT = 0
) (
  input wire sys_clk,
  input wire rst_n,
  input wire soft_rst,
  input wire downstream_port,
  input wire merged_mode,
  input wire ltssm_in_l0,
  input wire [LANES-1:0] rx_zero_insert,
  input wire [LANES-1:0] rx_byte_drop,
  input wire [`PLSC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire [15:0] ts_bits_in,
  output wire [15:0] ts_bits_out,
  output wire first_gen_compat_enable,
  output wire crosslink_disable,
  output wire crosslink_negotiate_en,
  output wire initial_speed_change_control,
  input wire ltssm_in_detect,
  input wire gen2_permitted,
  output wire speed_change_req,
  output wire irq
);
  localparam HALF = LANES / 2;

  reg [31:0] rdata_r;
  reg compat_r;
  reg xlink_r;
  reg speed_r;
  reg speed_init_done_r;
  reg [1:0] irq_sts_r;
  reg [1:0] irq_mask_r;
  reg seen_detect_r;
  reg speed_req_r;
  reg first_l0_done_r;
  reg l0_prev_r;
  wire [LANES-1:0] und_flags;
  wire [LANES-1:0] ovr_flags;
  wire [LANES-1:0] lane_valid;
  wire [LANES-1:0] rx_underflow_flags;
  wire [LANES-1:0] rx_overflow_flags;
  wire wr_sts;
  wire wr_cfg;
  wire wr_mask;
  wire rd_irq;
  wire und_evt;
  wire ovr_evt;
  wire l0_entry;

  // Address decode for the plain register port
  assign wr_sts = reg_wr && (reg_addr == `PLSC_OFS_LANE_STS);
  assign wr_cfg = reg_wr && (reg_addr == `PLSC_OFS_LINK_CFG);
  assign wr_mask = reg_wr && (reg_addr == `PLSC_OFS_IRQ_MASK);
  assign rd_irq = reg_rd && (reg_addr == `PLSC_OFS_IRQ_STS);

  // Upper lanes exist only on an even port in merged mode
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      if (g < HALF) begin : g_low
        assign lane_valid[g] = 1'b1;
      end else begin : g_high
        assign lane_valid[g] = (ODD_PORT == 0) && merged_mode;
      end
      plsc_lane_flag u_und (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .event_in(rx_zero_insert[g]),
        .in_l0(ltssm_in_l0),
        .lane_valid(lane_valid[g]),
        .clr_in(wr_sts && reg_wdata[`PLSC_UND_LSB + g]),
        .flag(und_flags[g])
      );
      plsc_lane_flag u_ovr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .event_in(rx_byte_drop[g]),
        .in_l0(ltssm_in_l0),
        .lane_valid(lane_valid[g]),
        .clr_in(wr_sts && reg_wdata[`PLSC_OVR_LSB + g]),
        .flag(ovr_flags[g])
      );
    end
  endgenerate

  // Odd ports report upper lanes as zero; software must ignore them
  assign rx_underflow_flags = und_flags;
  assign rx_overflow_flags = ovr_flags;

  // Interrupt events: any qualified lane event of each kind
  assign und_evt = |(rx_zero_insert & lane_valid) && ltssm_in_l0;
  assign ovr_evt = |(rx_byte_drop & lane_valid) && ltssm_in_l0;

  // Sticky interrupt status, cleared by a read, set wins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      irq_sts_r <= (rd_irq ? 2'h0 : irq_sts_r) | {ovr_evt, und_evt};
      if (wr_mask) begin
        irq_mask_r <= reg_wdata[1:0];
      end
    end
  end

  assign irq = |(irq_sts_r & irq_mask_r);

  // Link configuration; software resets leave these alone
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compat_r <= 1'b0;
      xlink_r <= 1'b0;
      speed_r <= `PLSC_SPEED_RST_OTHER;
      speed_init_done_r <= 1'b0;
    end else begin
      if (!speed_init_done_r) begin
        speed_init_done_r <= 1'b1;
        speed_r <= downstream_port ? `PLSC_SPEED_RST_DSP : `PLSC_SPEED_RST_OTHER;
      end else if (wr_cfg) begin
        speed_r <= reg_wdata[`PLSC_SPEED_BIT];
      end
      if (wr_cfg) begin
        compat_r <= reg_wdata[`PLSC_COMPAT_BIT];
        xlink_r <= reg_wdata[`PLSC_XLINK_BIT];
      end
    end
  end

  assign first_gen_compat_enable = compat_r;
  assign crosslink_disable = xlink_r;
  assign crosslink_negotiate_en = ~xlink_r;
  assign initial_speed_change_control = speed_r;

  // With compat_r set, training set bits beyond the first-generation set are forced low; otherwise they pass through
  assign ts_bits_out = compat_r ? {8'h00, ts_bits_in[7:0]} : ts_bits_in;

  // First L0 entry after Detect triggers one Gen2 speed change request when speed_r is clear and gen2_permitted is high
  assign l0_entry = ltssm_in_l0 && !l0_prev_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      l0_prev_r <= 1'b0;
      seen_detect_r <= 1'b0;
      first_l0_done_r <= 1'b0;
      speed_req_r <= 1'b0;
    end else begin
      l0_prev_r <= ltssm_in_l0;
      speed_req_r <= 1'b0;
      if (soft_rst) begin
        seen_detect_r <= 1'b0;
        first_l0_done_r <= 1'b0;
      end else begin
        if (ltssm_in_detect) begin
          seen_detect_r <= 1'b1;
        end
        if (l0_entry && seen_detect_r && !first_l0_done_r) begin
          first_l0_done_r <= 1'b1;
          speed_req_r <= !speed_r && gen2_permitted;
        end
      end
    end
  end

  assign speed_change_req = speed_req_r;

  // Registered read data; reserved bits and unmapped addresses read zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `PLSC_OFS_LANE_STS: rdata_r <= {8'h00, rx_overflow_flags, 8'h00, rx_underflow_flags};
          `PLSC_OFS_LINK_CFG: rdata_r <= {17'h00000, speed_r, 2'h0, xlink_r, 2'h0, compat_r, 8'h00};
          `PLSC_OFS_IRQ_STS: rdata_r <= {30'h00000000, irq_sts_r};
          `PLSC_OFS_IRQ_MASK: rdata_r <= {30'h00000000, irq_mask_r};
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

//--- testbench/plsc_checker.sv
// Port assertions for the lane status and link config slice
`timescale 1ns/1ns
`default_nettype none
module plsc_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] ts_bits_in,
  input wire logic [15:0] ts_bits_out,
  input wire logic first_gen_compat_enable,
  input wire logic crosslink_disable,
  input wire logic crosslink_negotiate_en,
  input wire logic initial_speed_change_control,
  input wire logic speed_change_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire cfg_rd = reg_rd && reg_addr == 12'h530;
  wire sts_rd = reg_rd && reg_addr == 12'h520;
  // Read data shape
  chk_cfg_resv: assert property (cfg_rd |=> (reg_rdata & 32'hffffb6ff) == 0)
    else $error("cfg reserved set");
  chk_sts_resv: assert property (sts_rd |=> (reg_rdata & 32'hff00ff00) == 0)
    else $error("status reserved set");
  chk_idle_zero: assert property (!reg_rd |=> reg_rdata == 0)
    else $error("stray read data");
  chk_cfg_value: assert property (cfg_rd |=> reg_rdata[14] == $past(initial_speed_change_control))
    else $error("speed bit readback");
  // Config outputs
  chk_compat_ts: assert property (first_gen_compat_enable |-> ts_bits_out[15:8] == 0)
    else $error("compat bits kept");
  chk_ts_pass: assert property (ts_bits_out[7:0] == ts_bits_in[7:0] && (first_gen_compat_enable || ts_bits_out[15:8] == ts_bits_in[15:8]))
    else $error("training bits altered");
  chk_xlink_neg: assert property (crosslink_negotiate_en != crosslink_disable)
    else $error("crosslink negotiate");
  chk_speed_gate: assert property (speed_change_req |-> !$past(initial_speed_change_control))
    else $error("speed change disabled");
  chk_req_pulse: assert property (speed_change_req |=> !speed_change_req)
    else $error("speed request long");
  cover property (speed_change_req);
  cover property (sts_rd ##1 reg_rdata != 0);
  cover property (cfg_rd && first_gen_compat_enable);
endmodule
bind plsc_top plsc_checker u_plsc_checker (.sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .ts_bits_in, .ts_bits_out,
  .first_gen_compat_enable, .crosslink_disable, .crosslink_negotiate_en, .initial_speed_change_control,
  .speed_change_req);
`default_nettype wire

//--- testbench/plsc_link_partner.sv
// Link partner model
`timescale 1ns/1ns
`default_nettype none
module plsc_link_partner (
  input wire logic sys_clk,
  input wire logic link_up,
  input wire logic [15:0] ev_req,
  output logic ltssm_in_detect = 1,
  output logic ltssm_in_l0 = 0,
  output logic [15:0] ev = 0
);
  // Detect while down, L0 after detect, events a cycle late
  always @(posedge sys_clk) begin
    ltssm_in_detect <= !link_up;
    ltssm_in_l0 <= link_up && (ltssm_in_l0 || ltssm_in_detect);
    ev <= ev_req;
  end
endmodule
`default_nettype wire

//--- testbench/test_plsc_top.sv
// Bench for the lane status and link config slice
`timescale 1ns/1ns
`default_nettype none
module test_plsc_top;
  logic sys_clk = 0, rst_n = 0, soft_rst = 0, dsp = 0, mrg = 1, link_up = 0, gen2 = 1;
  logic reg_wr = 0, reg_rd = 0, rd_q = 0, l0, det, irq, req;
  logic [11:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rnd = 32'h8b36, ev;
  logic [15:0] ts = 0, evr = 0, evo;
  logic [7:0] m;
  logic [31:0] exp_q[$];
  int err_count = 0, cmp_count = 0, pulses = 0;
  // Core clock
  always #5 sys_clk = ~sys_clk;
  plsc_top u_plsc_top (.sys_clk, .rst_n, .soft_rst, .downstream_port(dsp), .merged_mode(mrg), .ltssm_in_l0(l0),
    .rx_zero_insert(evo[7:0]), .rx_byte_drop(evo[15:8]), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ts_bits_in(ts), .ts_bits_out(), .first_gen_compat_enable(), .crosslink_disable(), .crosslink_negotiate_en(),
    .initial_speed_change_control(), .ltssm_in_detect(det), .gen2_permitted(gen2), .speed_change_req(req), .irq);
  plsc_link_partner u_plsc_link_partner (.sys_clk, .link_up, .ev_req(evr), .ltssm_in_detect(det),
    .ltssm_in_l0(l0), .ev(evo));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle plus lane events; a read queues its expected data
  task automatic bus(input logic w, r, input logic [11:0] a, input logic [31:0] d, input logic [15:0] e = 0);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata, evr} <= {w, r, a, d, e};
    ts <= ts + 16'h9e37;
    if (r)
      exp_q.push_back(d);
  endtask
  // Oldest note meets the read data; speed requests counted
  always @(negedge sys_clk) begin
    if (rd_q)
      chk(reg_rdata, exp_q.pop_front());
    rd_q = reg_rd;
    pulses += (req === 1'b1);
  end
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #50000;
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1;
    bus(0, 0, 0, 0);
    bus(0, 1, 12'h520, 0);
    bus(0, 1, 12'h530, 32'h4000);
    bus(0, 1, 12'h524, 0);
    bus(1, 0, 12'h530, '1);
    bus(0, 1, 12'h530, 32'h4900, '1);
    repeat (3) bus(0, 0, 0, 0);
    bus(0, 1, 12'h520, 0);
    link_up <= 1;
    bus(0, 0, 0, 0, 16'h0001);
    repeat (3) bus(0, 0, 0, 0);
    @(negedge sys_clk) chk(irq, 0);
    bus(0, 1, 12'h534, 1);
    bus(1, 0, 12'h538, 3);
    bus(1, 0, 12'h520, '1);
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      m = rnd[16] ? 8'hff : 8'h0f;
      mrg <= rnd[16];
      ev = {8'h0, rnd[15:8] & m, 8'h0, rnd[7:0] & m};
      bus(0, 0, 0, 0, rnd[15:0]);
      repeat (3) bus(0, 0, 0, 0);
      @(negedge sys_clk) chk(irq, ev != 0);
      bus(0, 1, 12'h520, ev);
      bus(0, 1, 12'h534, {ev[23:16] != 0, ev[7:0] != 0});
      bus(1, 0, 12'h520, 32'h00f000f0);
      bus(0, 1, 12'h520, ev & 32'hff0fff0f);
      bus(1, 0, 12'h520, '1);
      @(negedge sys_clk) chk(irq, 0);
    end
    link_up <= 0;
    dsp <= 1;
    bus(0, 0, 0, 0);
    rst_n <= 0;
    bus(0, 0, 0, 0);
    rst_n <= 1;
    bus(0, 0, 0, 0);
    bus(0, 1, 12'h530, 0);
    link_up <= 1;
    repeat (4) bus(0, 0, 0, 0);
    chk(pulses, 1);
    bus(1, 0, 12'h530, 32'h4000);
    soft_rst <= 1;
    bus(0, 0, 0, 0);
    soft_rst <= 0;
    link_up <= 0;
    bus(0, 1, 12'h530, 32'h4000);
    link_up <= 1;
    repeat (4) bus(0, 0, 0, 0);
    chk(pulses, 1);
    // Automatic mode but Gen2 not permitted: still no request
    bus(1, 0, 12'h530, 0);
    gen2 <= 0;
    soft_rst <= 1;
    bus(0, 0, 0, 0);
    soft_rst <= 0;
    link_up <= 0;
    bus(0, 1, 12'h530, 0);
    link_up <= 1;
    repeat (4) bus(0, 0, 0, 0);
    chk(pulses, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
